// [src/ccz_defines.vh]
`ifndef CCZ_DEFINES_VH
`define CCZ_DEFINES_VH

// Register byte offsets
`define CCZ_REG_LOCK      12'h000
`define CCZ_REG_CMD       12'h004
`define CCZ_REG_CMD_AUX   12'h008
`define CCZ_REG_SLOT_POL  12'h00C
`define CCZ_REG_TKEY      12'h010
`define CCZ_REG_POWER     12'h014
`define CCZ_REG_STATUS    12'h018
`define CCZ_REG_DIGEST    12'h01C

// Lock register fields
`define CCZ_LOCK_CFG_BIT  0
`define CCZ_LOCK_DATA_BIT 1
`define CCZ_LOCK_OTP_LSB  2

// Otp policy mode codes
`define CCZ_OTP_READ_ONLY   2'h1
`define CCZ_OTP_CONSUMPTION 2'h2

// Zone codes in the first parameter byte
`define CCZ_ZONE_CONFIG 8'h00
`define CCZ_ZONE_OTP    8'h01
`define CCZ_ZONE_DATA   8'h02

// Opcodes
`define CCZ_OP_READ  8'h02
`define CCZ_OP_WRITE 8'h12
`define CCZ_OP_MAC   8'h28

// Result and error codes
`define CCZ_RES_OK       8'h00
`define CCZ_RES_MISMATCH 8'h01
`define CCZ_RES_PARSE    8'h03
`define CCZ_RES_EXEC     8'h0F
`define CCZ_RES_WDOG     8'hEE

// Config zone write limits in bytes
`define CCZ_CFG_WR_FIRST  8'h10
`define CCZ_CFG_XTRA_LO   8'h54
`define CCZ_CFG_XTRA_HI   8'h57

// Watchdog interval and command guard
`define CCZ_CLK_MHZ       100
`define CCZ_WDOG_MS       13
`define CCZ_WDOG_CYCLES   (`CCZ_WDOG_MS * 1000 * `CCZ_CLK_MHZ)
`define CCZ_GUARD_US      100
`define CCZ_GUARD_CYCLES  (`CCZ_GUARD_US * `CCZ_CLK_MHZ)

`endif

// [src/ccz_top.v]
// Summary of operation
// - First parameter byte picks zone: 0 config, 1 otp, 2 data.
// - Config zone always readable; partly writable unlocked, never locked, never encrypted.
// - Otp zone unreadable until locked; writable unlocked; locked writes per otp policy.
// - Data zone unreadable unlocked; locked reads per secret/encrypt flags, writes per policy.
// - Wake token starts watchdog; expiry forces sleep even mid-transfer or mid-command.
// - Only sleep or idle followed by a new wake restarts the watchdog.
// - Sleep clears volatile state; idle keeps temporary key and random seed.
// - Too little watchdog time left: return timeout code, do not execute.
// - Limited-use count decrements before the crypto computation starts; code pulses use_dec_q in the same cycle as hash_req_q.
// - Opcode 0x28 computes the MAC, compares with client response, reports match.
// - Mode bit 1 picks slot or temporary key for first 32 message bytes.
// - Mode bit 0 picks challenge input or temporary key for second 32 bytes.
// - Mode bits 7-3 zero; with bit 0 or 1 set, bit 2 equals nonce origin.
// - Random nonce required by key policy: error unless nonce came from generator.
// - Match with mode bit 1 clear sets authorization flag and records slot index.
// - Match with mode 0x01 or 0x05 and zero read key copies paired slot to key.
// - Only low four bits of the slot index parameter are used.
// - Result byte is zero on match and one on mismatch.
//
// Decided for this implementation: the register offsets and the APB register port.
`timescale 1ns/1ps
`include "ccz_defines.vh"

module ccz_top #(
  parameter WDOG_CYCLES  = `CCZ_WDOG_CYCLES,
  parameter GUARD_CYCLES = `CCZ_GUARD_CYCLES
) (
  input  wire        clk,
  input  wire        resetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata_q,
  output reg         pready_q,
  output reg         pslverr_q,
  input  wire        link_clk,
  input  wire        link_data,
  output reg         hash_req_q,
  output reg         hash_first_tkey_q,
  output reg         hash_second_tkey_q,
  output reg  [3:0]  hash_slot_q,
  input  wire        hash_done,
  input  wire        hash_match,
  output reg         use_dec_q,
  output reg  [3:0]  use_dec_slot_q,
  output reg         tkey_copy_q,
  output reg  [3:0]  tkey_copy_slot_q,
  output reg         awake_q
);

  localparam [3:0] ST_READY = 4'b0001;
  localparam [3:0] ST_USE   = 4'b0010;
  localparam [3:0] ST_HASH  = 4'b0100;
  localparam [3:0] ST_FIN   = 4'b1000;

  // Watchdog counter width covers the default interval
  localparam WDW = 32;

  reg [3:0]     state_q;
  reg           cfg_locked_q;
  reg           data_locked_q;
  reg [1:0]     otp_mode_q;
  reg [7:0]     opcode_q;
  reg [7:0]     first_parameter_byte_q;
  reg [15:0]    second_parameter_word_q;
  reg           aux_write_q;
  reg           aux_enc_q;
  reg           aux_len32_q;
  reg [7:0]     result_q;
  reg           busy_q;
  reg           done_q;
  reg           tkey_valid_q;
  reg           nonce_origin_flag_q;
  reg           authorization_valid_flag_q;
  reg [3:0]     authorized_slot_index_q;
  reg           idle_q;
  reg [WDW-1:0] wdog_q;
  reg           lclk_s1_q;
  reg           lclk_s2_q;
  reg           lclk_s3_q;
  reg           ldat_s1_q;
  reg           ldat_s2_q;

  // Per-slot policy table
  reg           slot_secret_flag_q     [0:15];
  reg           encrypted_read_flag_q  [0:15];
  reg [3:0]     slot_write_policy_q    [0:15];
  reg [3:0]     read_key_selector_q    [0:15];
  reg           use_limit_flag_q       [0:15];
  reg           require_random_nonce_q [0:15];

  wire          apb_setup  = psel && penable && !pready_q;
  wire          apb_commit = psel && penable && pready_q;
  wire          wr_commit  = apb_commit && pwrite;
  wire [3:0]    slot_idx   = second_parameter_word_q[3:0];
  wire [3:0]    pair_slot  = slot_idx[0] ? slot_idx : slot_idx + 4'h1;
  wire [3:0]    data_slot  = second_parameter_word_q[6:3];
  wire          wake_tok   = lclk_s2_q && !lclk_s3_q && !ldat_s2_q;
  wire          wdog_exp   = awake_q && !idle_q && (wdog_q >= WDOG_CYCLES - 1);
  wire          sleep_wr   = wr_commit && (paddr == `CCZ_REG_POWER) && pwdata[1];
  wire          idle_wr    = wr_commit && (paddr == `CCZ_REG_POWER) && pwdata[0];
  wire          go_sleep   = wdog_exp || sleep_wr;
  wire          cmd_wr     = wr_commit && (paddr == `CCZ_REG_CMD) && awake_q && !idle_q && !busy_q;
  wire          zone_bad;
  wire          zone_allow;
  wire [7:0]    mode       = first_parameter_byte_q;

  ccz_zone_check u_zone (
    .zone                (first_parameter_byte_q),
    .word_addr           (second_parameter_word_q),
    .is_write            (aux_write_q),
    .encrypted           (aux_enc_q),
    .len32               (aux_len32_q),
    .cfg_locked          (cfg_locked_q),
    .data_locked         (data_locked_q),
    .otp_policy_mode     (otp_mode_q),
    .slot_secret_flag    (slot_secret_flag_q[data_slot]),
    .encrypted_read_flag (encrypted_read_flag_q[data_slot]),
    .slot_write_policy   (slot_write_policy_q[data_slot]),
    .bad_zone            (zone_bad),
    .allow               (zone_allow)
  );

  // Watchdog margin check shared by every command
  function time_short;
    input [WDW-1:0] count;
    begin
      time_short = (count + GUARD_CYCLES >= WDOG_CYCLES);
    end
  endfunction

  function mac_mode_ok;
    input [7:0] m;
    input       origin;
    begin
      mac_mode_ok = (m[7:3] == 5'h00) && (!(m[0] || m[1]) || (m[2] == origin));
    end
  endfunction

  // Link pins are asynchronous to clk
  always @(posedge clk) begin
    if (!resetn) begin
      lclk_s1_q <= 1'b0;
      lclk_s2_q <= 1'b0;
      lclk_s3_q <= 1'b0;
      ldat_s1_q <= 1'b1;
      ldat_s2_q <= 1'b1;
    end else begin
      lclk_s1_q <= link_clk;
      lclk_s2_q <= lclk_s1_q;
      lclk_s3_q <= lclk_s2_q;
      ldat_s1_q <= link_data;
      ldat_s2_q <= ldat_s1_q;
    end
  end

  // Power state and watchdog
  always @(posedge clk) begin
    if (!resetn) begin
      awake_q <= 1'b0;
      idle_q  <= 1'b0;
      wdog_q  <= {WDW{1'b0}};
    end else if (go_sleep) begin
      awake_q <= 1'b0;
      idle_q  <= 1'b0;
      wdog_q  <= {WDW{1'b0}};
    end else if (idle_wr && awake_q) begin
      idle_q  <= 1'b1;
      wdog_q  <= {WDW{1'b0}};
    end else if (wake_tok && (!awake_q || idle_q)) begin
      awake_q <= 1'b1;
      idle_q  <= 1'b0;
      wdog_q  <= {WDW{1'b0}};
    end else if (awake_q && !idle_q) begin
      wdog_q  <= wdog_q + {{(WDW-1){1'b0}}, 1'b1};
    end
  end

  // Slot policy table writes
  always @(posedge clk) begin
    if (wr_commit && (paddr == `CCZ_REG_SLOT_POL)) begin
      slot_secret_flag_q[pwdata[3:0]]     <= pwdata[8];
      encrypted_read_flag_q[pwdata[3:0]]  <= pwdata[9];
      use_limit_flag_q[pwdata[3:0]]       <= pwdata[10];
      require_random_nonce_q[pwdata[3:0]] <= pwdata[11];
      slot_write_policy_q[pwdata[3:0]]    <= pwdata[15:12];
      read_key_selector_q[pwdata[3:0]]    <= pwdata[19:16];
    end
  end

  // Configuration and command registers
  always @(posedge clk) begin
    if (!resetn) begin
      cfg_locked_q            <= 1'b0;
      data_locked_q           <= 1'b0;
      otp_mode_q              <= 2'h0;
      opcode_q                <= 8'h00;
      first_parameter_byte_q  <= 8'h00;
      second_parameter_word_q <= 16'h0000;
      aux_write_q             <= 1'b0;
      aux_enc_q               <= 1'b0;
      aux_len32_q             <= 1'b0;
    end else begin
      if (wr_commit && (paddr == `CCZ_REG_LOCK)) begin
        cfg_locked_q  <= pwdata[`CCZ_LOCK_CFG_BIT];
        data_locked_q <= pwdata[`CCZ_LOCK_DATA_BIT];
        otp_mode_q    <= pwdata[`CCZ_LOCK_OTP_LSB+1:`CCZ_LOCK_OTP_LSB];
      end
      if (wr_commit && (paddr == `CCZ_REG_CMD_AUX) && !busy_q) begin
        aux_write_q <= pwdata[0];
        aux_enc_q   <= pwdata[1];
        aux_len32_q <= pwdata[2];
      end
      if (cmd_wr) begin
        opcode_q                <= pwdata[7:0];
        first_parameter_byte_q  <= pwdata[15:8];
        second_parameter_word_q <= pwdata[31:16];
      end
    end
  end

  // Command sequencer and volatile state
  always @(posedge clk) begin
    if (!resetn) begin
      state_q                    <= ST_READY;
      busy_q                     <= 1'b0;
      done_q                     <= 1'b0;
      result_q                   <= 8'h00;
      tkey_valid_q               <= 1'b0;
      nonce_origin_flag_q        <= 1'b0;
      authorization_valid_flag_q <= 1'b0;
      authorized_slot_index_q    <= 4'h0;
      hash_req_q                 <= 1'b0;
      hash_first_tkey_q          <= 1'b0;
      hash_second_tkey_q         <= 1'b0;
      hash_slot_q                <= 4'h0;
      use_dec_q                  <= 1'b0;
      use_dec_slot_q             <= 4'h0;
      tkey_copy_q                <= 1'b0;
      tkey_copy_slot_q           <= 4'h0;
    end else if (go_sleep) begin
      state_q                    <= ST_READY;
      busy_q                     <= 1'b0;
      done_q                     <= 1'b0;
      result_q                   <= 8'h00;
      tkey_valid_q               <= 1'b0;
      nonce_origin_flag_q        <= 1'b0;
      authorization_valid_flag_q <= 1'b0;
      authorized_slot_index_q    <= 4'h0;
      hash_req_q                 <= 1'b0;
      use_dec_q                  <= 1'b0;
      tkey_copy_q                <= 1'b0;
    end else begin
      hash_req_q  <= 1'b0;
      use_dec_q   <= 1'b0;
      tkey_copy_q <= 1'b0;
      if (wr_commit && (paddr == `CCZ_REG_TKEY) && !busy_q) begin
        tkey_valid_q        <= pwdata[0];
        nonce_origin_flag_q <= pwdata[1];
      end
      case (state_q)
        ST_READY: begin
          if (cmd_wr) begin
            busy_q  <= 1'b1;
            done_q  <= 1'b0;
            state_q <= ST_USE;
          end
        end
        ST_USE: begin
          state_q <= ST_FIN;
          if (time_short(wdog_q)) begin
            result_q <= `CCZ_RES_WDOG;
          end else if (opcode_q == `CCZ_OP_MAC) begin
            if (!mac_mode_ok(mode, nonce_origin_flag_q))
              result_q <= `CCZ_RES_PARSE;
            else if ((mode[0] || mode[1]) && !tkey_valid_q)
              result_q <= `CCZ_RES_EXEC;
            else if (require_random_nonce_q[slot_idx] && nonce_origin_flag_q)
              result_q <= `CCZ_RES_EXEC;
            else begin
              use_dec_q          <= use_limit_flag_q[slot_idx];
              use_dec_slot_q     <= slot_idx;
              hash_req_q         <= 1'b1;
              hash_first_tkey_q  <= mode[1];
              hash_second_tkey_q <= mode[0];
              hash_slot_q        <= slot_idx;
              state_q            <= ST_HASH;
            end
          end else if ((opcode_q == `CCZ_OP_READ) || (opcode_q == `CCZ_OP_WRITE)) begin
            if (zone_bad)
              result_q <= `CCZ_RES_PARSE;
            else if (!zone_allow)
              result_q <= `CCZ_RES_EXEC;
            else
              result_q <= `CCZ_RES_OK;
          end else begin
            result_q <= `CCZ_RES_PARSE;
          end
        end
        ST_HASH: begin
          if (hash_done) begin
            state_q <= ST_FIN;
            if (hash_match) begin
              result_q <= `CCZ_RES_OK;
              if (!mode[1]) begin
                authorization_valid_flag_q <= 1'b1;
                authorized_slot_index_q    <= slot_idx;
              end
              if (((mode == 8'h01) || (mode == 8'h05)) && (read_key_selector_q[pair_slot] == 4'h0)) begin
                tkey_copy_q      <= 1'b1;
                tkey_copy_slot_q <= pair_slot;
                tkey_valid_q     <= 1'b1;
              end
            end else begin
              result_q <= `CCZ_RES_MISMATCH;
            end
          end
        end
        ST_FIN: begin
          busy_q  <= 1'b0;
          done_q  <= 1'b1;
          state_q <= ST_READY;
        end
        default: state_q <= ST_READY;
      endcase
    end
  end

  // APB slave: one wait state, error on unmapped offsets
  always @(posedge clk) begin
    if (!resetn) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
    end else begin
      pready_q  <= apb_setup;
      pslverr_q <= 1'b0;
      if (apb_setup) begin
        prdata_q <= 32'h0000_0000;
        if (paddr == `CCZ_REG_LOCK)
          prdata_q <= {28'h000_0000, otp_mode_q, data_locked_q, cfg_locked_q};
        else if (paddr == `CCZ_REG_CMD)
          prdata_q <= {second_parameter_word_q, first_parameter_byte_q, opcode_q};
        else if (paddr == `CCZ_REG_CMD_AUX)
          prdata_q <= {29'h0000_0000, aux_len32_q, aux_enc_q, aux_write_q};
        else if (paddr == `CCZ_REG_SLOT_POL)
          prdata_q <= 32'h0000_0000;
        else if (paddr == `CCZ_REG_TKEY)
          prdata_q <= {30'h0000_0000, nonce_origin_flag_q, tkey_valid_q};
        else if (paddr == `CCZ_REG_POWER)
          prdata_q <= {29'h0000_0000, awake_q, 1'b0, idle_q};
        else if (paddr == `CCZ_REG_STATUS)
          prdata_q <= {11'h000, authorization_valid_flag_q, authorized_slot_index_q,
                       6'h00, done_q, busy_q, result_q};
        else if (paddr == `CCZ_REG_DIGEST)
          prdata_q <= {20'h0_0000, tkey_copy_slot_q, hash_slot_q, 1'b0, hash_second_tkey_q,
                       hash_first_tkey_q, hash_req_q};
        else
          pslverr_q <= 1'b1;
      end
    end
  end

endmodule // ccz_top

// [src/ccz_zone_check.v]
`timescale 1ns/1ps
`include "ccz_defines.vh"

module ccz_zone_check (
  input  wire [7:0]  zone,
  input  wire [15:0] word_addr,
  input  wire        is_write,
  input  wire        encrypted,
  input  wire        len32,
  input  wire        cfg_locked,
  input  wire        data_locked,
  input  wire [1:0]  otp_policy_mode,
  input  wire        slot_secret_flag,
  input  wire        encrypted_read_flag,
  input  wire [3:0]  slot_write_policy,
  output reg         bad_zone,
  output reg         allow
);

  reg [7:0] cfg_byte;

  always @* begin
    cfg_byte = {word_addr[5:0], 2'b00};
    bad_zone = 1'b0;
    allow    = 1'b0;
    if (zone == `CCZ_ZONE_CONFIG) begin
      if (!is_write)
        allow = 1'b1;
      else
        allow = !cfg_locked && !encrypted && (cfg_byte >= `CCZ_CFG_WR_FIRST) &&
                !(cfg_byte >= `CCZ_CFG_XTRA_LO && cfg_byte <= `CCZ_CFG_XTRA_HI);
    end else if (zone == `CCZ_ZONE_OTP) begin
      if (!is_write)
        allow = data_locked;
      else if (!data_locked)
        allow = 1'b1;
      else
        allow = (otp_policy_mode == `CCZ_OTP_CONSUMPTION);
    end else if (zone == `CCZ_ZONE_DATA) begin
      if (!is_write) begin
        if (!data_locked)
          allow = 1'b0;
        else if (slot_secret_flag)
          allow = encrypted_read_flag && encrypted && len32;
        else
          allow = !encrypted || encrypted_read_flag;
      end else if (!data_locked)
        allow = 1'b1;
      else if (slot_write_policy == 4'h0)
        allow = 1'b1;
      else if (slot_write_policy[2])
        allow = encrypted && len32;
      else
        allow = 1'b0;
    end else begin
      bad_zone = 1'b1;
    end
  end

endmodule // ccz_zone_check

// [verif/ccz_hash_model.sv]
`timescale 1ns/1ps
module ccz_hash_model (
  input  logic       clk,
  input  logic       resetn,
  input  logic       hash_req_q,
  input  logic [4:0] dly,
  input  logic       want,
  output logic       hash_done,
  output logic       hash_match
);
  logic [4:0] cnt_q;
  logic       busy_q;

  // Match toggles whenever done is low, so no stale value can pass
  // Done and match stand in for the host's challenge, response and 13 extra bytes
  always @(posedge clk) begin
    if (!resetn) begin
      busy_q     <= 1'b0;
      cnt_q      <= 5'h00;
      hash_done  <= 1'b0;
      hash_match <= 1'b0;
    end else begin
      hash_done  <= 1'b0;
      hash_match <= ~hash_match;
      if (hash_req_q) begin
        busy_q <= 1'b1;
        cnt_q  <= dly;
      end else if (busy_q && cnt_q == 5'h00) begin
        busy_q     <= 1'b0;
        hash_done  <= 1'b1;
        hash_match <= want;
      end else if (busy_q) begin
        cnt_q <= cnt_q - 5'h01;
      end
    end
  end
endmodule // ccz_hash_model

// [verif/ccz_monitor.sv]
`timescale 1ns/1ps
module ccz_monitor #(
  parameter WDOG_CYCLES  = 6000,
  parameter GUARD_CYCLES = 200
) (
  input logic       clk,
  input logic       resetn,
  input logic       psel,
  input logic       penable,
  input logic       pready_q,
  input logic       pslverr_q,
  input logic       hash_req_q,
  input logic       hash_first_tkey_q,
  input logic       hash_second_tkey_q,
  input logic [3:0] hash_slot_q,
  input logic       hash_done,
  input logic       hash_match,
  input logic       use_dec_q,
  input logic [3:0] use_dec_slot_q,
  input logic       tkey_copy_q,
  input logic [3:0] tkey_copy_slot_q,
  input logic       awake_q
);
  logic [31:0] wd_q;

  // Cycles spent awake since the last wake from sleep; idle time counts, a wake from idle does not restart it
  always @(posedge clk) begin
    if (!resetn || !awake_q) begin
      wd_q <= 32'h0000_0000;
    end else begin
      wd_q <= wd_q + 32'h0000_0001;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  ready_once_a: assert property (psel && penable && !pready_q |=> pready_q)
    else $error("APB access not answered after one cycle");
  ready_pulse_a: assert property (pready_q |=> !pready_q)
    else $error("APB ready held too long");
  err_pair_a: assert property (pslverr_q |-> pready_q)
    else $error("APB error without ready");
  dec_with_req_a: assert property (use_dec_q |-> hash_req_q && use_dec_slot_q == hash_slot_q)
    else $error("Use decrement apart from hash request");
  req_pulse_a: assert property (hash_req_q |=> !hash_req_q)
    else $error("Hash request longer than one cycle");
  copy_match_a: assert property (tkey_copy_q |-> $past(hash_done && hash_match))
    else $error("Key copy without a match");
  copy_slot_a: assert property (tkey_copy_q |-> tkey_copy_slot_q == {hash_slot_q[3:1], 1'b1}
    && !hash_first_tkey_q && hash_second_tkey_q)
    else $error("Key copy slot or mode wrong");
  wd_limit_a: assert property (awake_q |-> wd_q < WDOG_CYCLES + 8)
    else $error("Watchdog did not force sleep");
  guard_time_a: assert property (hash_req_q |-> wd_q + GUARD_CYCLES < WDOG_CYCLES + 4)
    else $error("Command started too close to watchdog expiry");
  asleep_quiet_a: assert property (!awake_q |-> !hash_req_q && !tkey_copy_q)
    else $error("Activity while asleep");

  cover property (hash_req_q);
  cover property (tkey_copy_q);
  cover property (pslverr_q);
  cover property ($fell(awake_q));
endmodule // ccz_monitor

bind ccz_top ccz_monitor #(.WDOG_CYCLES(WDOG_CYCLES), .GUARD_CYCLES(GUARD_CYCLES)) ccz_monitor_inst (.*);

// [verif/crypto_cmd_zone_watchdog_macchk_tb.sv]
`timescale 1ns/1ps
`include "ccz_defines.vh"
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin mismatches++; $display("Error %s expected %0h seen %0h", nm, e, g); end end
module crypto_cmd_zone_watchdog_macchk_tb;
  localparam WD = 6000;
  logic        clk, resetn, psel, penable, pwrite, link_clk, link_data, hash_done, hash_match, want;
  logic        pready_q, pslverr_q, er, hash_req_q, hash_first_tkey_q, hash_second_tkey_q;
  logic        use_dec_q, tkey_copy_q, awake_q;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata_q, rd, st, seed;
  logic [3:0]  hash_slot_q, use_dec_slot_q, tkey_copy_slot_q;
  logic [4:0]  dly;
  logic [7:0]  res, m;
  logic [3:0]  s;
  logic [7:0]  mm [10] = '{8'h01, 8'h02, 8'h00, 8'h08, 8'h05, 8'h00, 8'h07, 8'h01, 8'h04, 8'h05};
  logic [3:0]  ms [10] = '{4'h2, 4'h3, 4'h9, 4'h1, 4'h1, 4'h5, 4'h4, 4'h6, 4'h1, 4'h0};
  logic [9:0]  mo = 10'h260;
  logic [9:0]  mh = 10'h2FB;
  integer      mismatches, n_tests, ncopy, nexp, ndec, i, k, z, w, lk;

  ccz_top #(.WDOG_CYCLES(WD), .GUARD_CYCLES(200)) ccz_top_inst (.*);
  ccz_hash_model ccz_hash_model_inst (.*);

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk) if (resetn && tkey_copy_q === 1'b1) ncopy <= ncopy + 1;
  // Only slot 2 carries a use limit; a decrement on any other slot weighs 16
  always @(posedge clk) if (resetn && use_dec_q === 1'b1) ndec <= ndec + ((use_dec_slot_q === 4'h2) ? 1 : 16);

  function automatic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    xs = seed;
  endfunction

  function automatic [7:0] zres(input logic [3:0] a, input logic [7:0] b, input logic c);
    case (b)
      8'h00: zres = (c && a[0]) ? `CCZ_RES_EXEC : `CCZ_RES_OK;
      8'h01: zres = (c ? (a[1] && a[3:2] != 2'h2) : !a[1]) ? `CCZ_RES_EXEC : `CCZ_RES_OK;
      8'h02: zres = (!c && !a[1]) ? `CCZ_RES_EXEC : `CCZ_RES_OK;
      default: zres = `CCZ_RES_PARSE;
    endcase
  endfunction

  function automatic [7:0] mres(input logic [7:0] a, input logic [3:0] b, input logic o, input logic h);
    if (a[7:3] != 5'h00 || (a[1:0] != 2'h0 && a[2] != o)) mres = `CCZ_RES_PARSE;
    else if (b == 4'h5 && o) mres = `CCZ_RES_EXEC;
    else mres = h ? `CCZ_RES_OK : `CCZ_RES_MISMATCH;
  endfunction

  task automatic conclude();
    if (mismatches == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    integer t;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    for (t = 0; t < 20 && pready_q !== 1'b1; t++) @(posedge clk);
    if (t == 20) begin
      mismatches++;
      conclude();
    end
    rd = prdata_q;
    er = pslverr_q;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic run(input logic [31:0] c, input logic [2:0] x);
    integer t;
    apb(1'b1, `CCZ_REG_CMD_AUX, {29'h0000_0000, x});
    apb(1'b1, `CCZ_REG_CMD, c);
    for (t = 0; t < 200; t++) begin
      apb(1'b0, `CCZ_REG_STATUS, 32'h0000_0000);
      if (rd[9] === 1'b1) break;
    end
    if (t == 200) begin
      mismatches++;
      conclude();
    end
    st = rd;
    res = rd[7:0];
  endtask

  // Wake token: one link clock rise while data is held low
  task automatic wake();
    link_data <= 1'b0;
    repeat (4) @(posedge clk);
    link_clk <= 1'b1;
    repeat (4) @(posedge clk);
    link_clk <= 1'b0;
    repeat (4) @(posedge clk);
    link_data <= 1'b1;
    repeat (8) @(posedge clk);
    `CHK("awake", 1'b1, awake_q)
  endtask

  initial begin
    {psel, penable, pwrite, link_clk, resetn, want} = 6'h00;
    link_data = 1'b1;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    dly = 5'h00;
    seed = 41;
    {mismatches, n_tests, ncopy, nexp, ndec} = {32'd0, 32'd0, 32'd0, 32'd0, 32'd0};
    repeat (12) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    `CHK("asleep", 1'b0, awake_q)
    apb(1'b0, 12'h020, 32'h0000_0000);
    `CHK("slverr", 1'b1, er)
    `CHK("unmapped", 32'h0000_0000, rd)
    for (i = 0; i < 16; i++) apb(1'b1, `CCZ_REG_SLOT_POL, i | ((i == 2) << 10) | ((i == 5) << 11) | ((i == 7) << 16));
    wake();
    for (k = 0; k < 4; k++) begin
      lk = (k == 0) ? 0 : 4 * k - 1;
      apb(1'b1, `CCZ_REG_LOCK, lk);
      for (z = 0; z < 4; z++) for (w = 0; w < 2; w++) begin
        run({16'h0008, z[7:0], w[0] ? `CCZ_OP_WRITE : `CCZ_OP_READ}, {2'h2, w[0]});
        `CHK("zone", zres(lk[3:0], z[7:0], w[0]), res)
      end
    end
    apb(1'b1, `CCZ_REG_LOCK, 32'h0000_0000);
    run({16'h0008, `CCZ_ZONE_CONFIG, `CCZ_OP_WRITE}, 3'h7);
    `CHK("encwr", `CCZ_RES_EXEC, res)
    run({16'h0000, 8'h00, 8'h47}, 3'h0);
    `CHK("badop", `CCZ_RES_PARSE, res)
    apb(1'b1, `CCZ_REG_POWER, 32'h0000_0002);
    wake();
    for (i = 0; i < 10; i++) begin
      m = mm[i];
      s = ms[i];
      k = xs();
      dly <= k[4:0];
      want <= mh[i];
      apb(1'b1, `CCZ_REG_TKEY, {30'h0000_0000, mo[i], 1'b1});
      k = xs();
      run({k[11:0], s, m, `CCZ_OP_MAC}, 3'h0);
      `CHK("mac", mres(m, s, mo[i], mh[i]), res)
      if (mres(m, s, mo[i], mh[i]) == `CCZ_RES_OK && (m == 8'h01 || m == 8'h05) && s[3:1] != 3'h3) begin
        nexp++;
        `CHK("cpslot", {s[3:1], 1'b1}, tkey_copy_slot_q)
      end
      if (mres(m, s, mo[i], mh[i]) < 8'h02) begin
        `CHK("slot", s, hash_slot_q)
        `CHK("first", m[1], hash_first_tkey_q)
        `CHK("second", m[0], hash_second_tkey_q)
      end
      if (res == `CCZ_RES_OK && !m[1]) `CHK("auth", {1'b1, s}, st[20:16])
    end
    `CHK("copies", nexp, ncopy)
    apb(1'b1, `CCZ_REG_POWER, 32'h0000_0002);
    wake();
    apb(1'b1, `CCZ_REG_TKEY, 32'h0000_0001);
    repeat (WD - 150) @(posedge clk);
    run({16'h0001, 8'h00, `CCZ_OP_MAC}, 3'h0);
    `CHK("wdog", `CCZ_RES_WDOG, res)
    for (k = 0; k < 400 && awake_q !== 1'b0; k++) @(posedge clk);
    `CHK("expire", 1'b0, awake_q)
    apb(1'b0, `CCZ_REG_TKEY, 32'h0000_0000);
    `CHK("tkeysleep", 32'h0000_0000, rd)
    // Idle then wake keeps the temporary key across the gap
    wake();
    apb(1'b1, `CCZ_REG_TKEY, 32'h0000_0003);
    apb(1'b1, `CCZ_REG_POWER, 32'h0000_0001);
    repeat (20) @(posedge clk);
    wake();
    apb(1'b0, `CCZ_REG_TKEY, 32'h0000_0000);
    `CHK("tkeyidle", 32'h0000_0003, rd)
    apb(1'b1, `CCZ_REG_POWER, 32'h0000_0002);
    apb(1'b0, `CCZ_REG_TKEY, 32'h0000_0000);
    `CHK("tkeyclr", 32'h0000_0000, rd)
    `CHK("decs", 1, ndec)
    conclude();
  end
endmodule // crypto_cmd_zone_watchdog_macchk_tb
